/* File: pkg/cplsc_pkg.sv */
// cplsc_pkg: states, ack codes and sizing constants for the low-power state controller
// assumes a single 20 MHz clock domain (mclk) and synchronous active-low reset
package cplsc_pkg;
   // power states of the core
   typedef enum logic [2:0] {
      CPLSC_RUN,
      CPLSC_GRANT,
      CPLSC_SLEEP,
      CPLSC_DEEP,
      CPLSC_HANDLER
   } cplsc_state_e;
   // acknowledge transaction codes driven on the host bus
   localparam logic [1:0] CPLSC_ACK_NONE = 2'h0;
   localparam logic [1:0] CPLSC_ACK_GRANT = 2'h1;
   localparam logic [1:0] CPLSC_ACK_MGMT = 2'h2;
   // synchroniser depth
   localparam int CPLSC_SYNC_STAGES = 2;
   // mclk cycles with no bus clock edge that count as a stopped bus clock
   localparam int CPLSC_BCLK_STOP_CYCLES = 8;
   localparam int CPLSC_BCLK_CNT_W = 4;
   // clock gate bit positions
   localparam int CPLSC_GATE_CORE = 0;
   localparam int CPLSC_GATE_BUS = 1;
   localparam int CPLSC_GATE_LIU = 2;
   localparam int CPLSC_GATE_W = 3;
endpackage

/* File: core/cplsc_sync.sv */
// cplsc_sync: multi-stage level synchroniser for one asynchronous input
// assumes nothing beyond mclk and nrst; output resets to the given idle level
`timescale 1ns/100ps
module cplsc_sync #(
   parameter int STAGES = 2,
   parameter logic IDLE = 1'b1
)
(
   input wire logic mclk, // system clock
   input wire logic nrst, // synchronous reset, active low
   input wire logic din, // asynchronous input
   output logic dout // synchronised level
);
   logic [STAGES-1:0] pipe;
   logic [STAGES-1:0] next_pipe;

   // shift chain; only the next stage reads each earlier stage
   always_comb
   begin
      next_pipe = {pipe[STAGES-2:0], din};
      if (!nrst)
      begin
         next_pipe = {STAGES{IDLE}};
      end
   end

   always_ff @(posedge mclk)
   begin
      pipe <= next_pipe;
   end

   assign dout = pipe[STAGES-1];
endmodule

/* File: core/cplsc_ctrl.sv */
// cplsc_ctrl: core low-power state machine, clock gating and ack issue
// assumes request pins are asynchronous and bclk_in is sampled as data on mclk
`timescale 1ns/100ps
// Notes on behaviour
// - In the grant state an asserted sleep request moves the core to sleep.
// - In sleep every unit clock is gated off and only the PLL keeps running.
// - In sleep snoops and interrupts of every kind are ignored.
// - In sleep only reset, sleep release, deep-sleep request and a stopped bus clock have any effect.
// - Releasing the sleep request in sleep returns to grant and restarts bus and local interrupt unit clocks.
// - In sleep a stopped bus clock or a deep-sleep request moves the core to deep sleep.
// - An accepted management interrupt saves state and enters the protected handler mode.
// - Entering the protected handler mode issues a management acknowledge on the host bus.
// - A management interrupt seen as reset is released sets outputs_tristate, which only holds off the host bus ack drive.
// - An asserted clock stop request enters the grant state.
// - Entering the grant state from run issues a grant acknowledge on the host bus.
// - In grant only the host bus unit and local interrupt unit keep clocks.
// - In grant snooping and interrupt service continue.
// - Releasing clock stop restarts all clocks and resumes execution.
// - Clock stop leaves the bus clock alone and is treated as asynchronous.
module cplsc_ctrl
   import cplsc_pkg::*;
(
   input wire logic mclk, // 20 MHz system clock
   input wire logic nrst, // synchronous reset, active low
   input wire logic bclk_in, // bus clock sampled as data
   input wire logic sleep_request_n, // async sleep request
   input wire logic deep_sleep_request_n, // async deep sleep request
   input wire logic clock_stop_request_n, // async clock stop request
   input wire logic mgmt_interrupt_n, // async management interrupt
   input wire logic handler_exit, // pulse: handler finished, resume
   input wire logic snoop_req, // bus snoop request
   input wire logic intr_req, // interrupt request
   output logic [cplsc_pkg::CPLSC_GATE_W-1:0] clk_en, // per-unit clock enables
   output logic [1:0] ack_code, // host bus ack transaction code
   output logic ack_valid, // one-cycle ack pulse
   output logic ack_oe, // host bus ack drive enable
   output logic save_state, // one-cycle state save pulse
   output logic handler_mode, // protected handler mode active
   output logic snoop_ack, // snoop accepted
   output logic intr_ack, // interrupt accepted
   output logic outputs_tristate, // host bus ack drive released
   output logic [2:0] state_out // current power state
);
   import cplsc_pkg::*;

   logic slp_s, dslp_s, stp_s, mgmt_s;
   cplsc_state_e state, next_state;
   logic [CPLSC_GATE_W-1:0] next_clk_en;
   logic [1:0] next_ack_code;
   logic next_ack_valid, next_save_state, next_snoop_ack, next_intr_ack;
   logic next_handler_mode, next_ack_oe;
   logic tri_q, next_tri_q;
   logic [3:0] rel_cnt, next_rel_cnt;
   logic bclk_d, next_bclk_d;
   logic [CPLSC_BCLK_CNT_W-1:0] bcnt, next_bcnt;
   logic bclk_stopped;

   // synchronisers for the request pins
   cplsc_sync #(.STAGES(CPLSC_SYNC_STAGES), .IDLE(1'b1)) u_slp (.mclk(mclk), .nrst(nrst),
      .din(sleep_request_n), .dout(slp_s));
   cplsc_sync #(.STAGES(CPLSC_SYNC_STAGES), .IDLE(1'b1)) u_dslp (.mclk(mclk), .nrst(nrst),
      .din(deep_sleep_request_n), .dout(dslp_s));
   cplsc_sync #(.STAGES(CPLSC_SYNC_STAGES), .IDLE(1'b1)) u_stp (.mclk(mclk), .nrst(nrst),
      .din(clock_stop_request_n), .dout(stp_s));
   cplsc_sync #(.STAGES(CPLSC_SYNC_STAGES), .IDLE(1'b1)) u_mgmt (.mclk(mclk), .nrst(nrst),
      .din(mgmt_interrupt_n), .dout(mgmt_s));

   assign bclk_stopped = (bcnt == CPLSC_BCLK_CNT_W'(CPLSC_BCLK_STOP_CYCLES));

   // bus clock activity monitor and reset-release strap
   always_comb
   begin
      next_bclk_d = bclk_in;
      next_bcnt = bcnt;
      if (bclk_in != bclk_d)
      begin
         next_bcnt = '0;
      end
      else if (!bclk_stopped)
      begin
         next_bcnt = bcnt + 1'b1;
      end
      next_rel_cnt = rel_cnt;
      next_tri_q = tri_q;
      // count edges after reset release; the sync chain is held idle during reset
      if (rel_cnt != 4'(CPLSC_SYNC_STAGES + 1))
      begin
         next_rel_cnt = rel_cnt + 1'b1;
      end
      // the chain now shows the pin as it stood at the release edge
      if (rel_cnt == 4'(CPLSC_SYNC_STAGES))
      begin
         next_tri_q = !mgmt_s;
      end
      if (!nrst)
      begin
         next_bcnt = '0;
         next_rel_cnt = '0;
         next_tri_q = 1'b0;
      end
   end

   always_ff @(posedge mclk)
   begin
      bclk_d <= next_bclk_d;
      bcnt <= next_bcnt;
      rel_cnt <= next_rel_cnt;
      tri_q <= next_tri_q;
   end

   // power state machine and output decode
   always_comb
   begin
      next_state = state;
      next_ack_code = CPLSC_ACK_NONE;
      next_ack_valid = 1'b0;
      next_save_state = 1'b0;
      case (state)
         CPLSC_RUN:
         begin
            if (!mgmt_s)
            begin
               next_state = CPLSC_HANDLER;
               next_save_state = 1'b1;
               next_ack_code = CPLSC_ACK_MGMT;
               next_ack_valid = 1'b1;
            end
            else if (!stp_s)
            begin
               next_state = CPLSC_GRANT;
               next_ack_code = CPLSC_ACK_GRANT;
               next_ack_valid = 1'b1;
            end
         end
         CPLSC_GRANT:
         begin
            if (stp_s)
            begin
               next_state = CPLSC_RUN;
            end
            else if (!slp_s)
            begin
               next_state = CPLSC_SLEEP;
            end
         end
         CPLSC_SLEEP:
         begin
            // only sleep release, deep sleep request or stopped bus clock act
            if (slp_s)
            begin
               next_state = CPLSC_GRANT;
            end
            else if (!dslp_s || bclk_stopped)
            begin
               next_state = CPLSC_DEEP;
            end
         end
         CPLSC_DEEP:
         begin
            if (dslp_s && !bclk_stopped)
            begin
               next_state = CPLSC_SLEEP;
            end
         end
         CPLSC_HANDLER:
         begin
            if (handler_exit)
            begin
               next_state = CPLSC_RUN;
            end
         end
         default:
         begin
            next_state = CPLSC_RUN;
         end
      endcase
      // clock gating per state
      case (next_state)
         CPLSC_RUN, CPLSC_HANDLER: next_clk_en = '1;
         CPLSC_GRANT: next_clk_en = CPLSC_GATE_W'((1 << CPLSC_GATE_BUS) | (1 << CPLSC_GATE_LIU));
         default: next_clk_en = '0;
      endcase
      // snoops and interrupts served except in sleep and deep sleep
      next_snoop_ack = snoop_req && (state != CPLSC_SLEEP) && (state != CPLSC_DEEP);
      next_intr_ack = intr_req && (state != CPLSC_SLEEP) && (state != CPLSC_DEEP);
      if (!nrst)
      begin
         next_state = CPLSC_RUN;
         next_clk_en = '1;
         next_ack_code = CPLSC_ACK_NONE;
         next_ack_valid = 1'b0;
         next_save_state = 1'b0;
         next_snoop_ack = 1'b0;
         next_intr_ack = 1'b0;
      end
      // handler flag and ack drive follow the next state and the strap
      next_handler_mode = (next_state == CPLSC_HANDLER);
      next_ack_oe = next_ack_valid && !next_tri_q;
   end

   always_ff @(posedge mclk)
   begin
      state <= next_state;
      clk_en <= next_clk_en;
      ack_code <= next_ack_code;
      ack_valid <= next_ack_valid;
      save_state <= next_save_state;
      snoop_ack <= next_snoop_ack;
      intr_ack <= next_intr_ack;
      handler_mode <= next_handler_mode;
      state_out <= 3'(next_state);
      ack_oe <= next_ack_oe;
      outputs_tristate <= next_tri_q;
   end

   // checks
   chk_sleep_entry: assert property (@(posedge mclk) disable iff (!nrst)
      state == CPLSC_GRANT && stp_s == 1'b0 && !slp_s |=> state == CPLSC_SLEEP)
      else $error("grant did not enter sleep");
   chk_sleep_gates: assert property (@(posedge mclk) disable iff (!nrst)
      state == CPLSC_SLEEP |-> clk_en == '0)
      else $error("clocks running in sleep");
   chk_sleep_snoop: assert property (@(posedge mclk) disable iff (!nrst)
      $past(state) == CPLSC_SLEEP |-> !snoop_ack && !intr_ack)
      else $error("snoop or interrupt taken in sleep");
   chk_sleep_hold: assert property (@(posedge mclk) disable iff (!nrst)
      state == CPLSC_SLEEP && !slp_s && dslp_s && !bclk_stopped |=> state == CPLSC_SLEEP)
      else $error("sleep left without cause");
   chk_sleep_exit: assert property (@(posedge mclk) disable iff (!nrst)
      state == CPLSC_SLEEP && slp_s |=> state == CPLSC_GRANT ##0 clk_en[CPLSC_GATE_BUS])
      else $error("sleep release failed");
   chk_deep_entry: assert property (@(posedge mclk) disable iff (!nrst)
      state == CPLSC_SLEEP && !slp_s && (!dslp_s || bclk_stopped) |=> state == CPLSC_DEEP)
      else $error("deep sleep not entered");
   chk_mgmt_ack: assert property (@(posedge mclk) disable iff (!nrst)
      $rose(handler_mode) |-> ack_valid && ack_code == CPLSC_ACK_MGMT && save_state)
      else $error("handler entry without ack");
   chk_grant_ack: assert property (@(posedge mclk) disable iff (!nrst)
      $rose(state == CPLSC_GRANT) && $past(state) == CPLSC_RUN |-> ack_valid && ack_code == CPLSC_ACK_GRANT)
      else $error("grant entry without ack");
   chk_grant_gates: assert property (@(posedge mclk) disable iff (!nrst)
      state == CPLSC_GRANT |-> clk_en == CPLSC_GATE_W'(6))
      else $error("grant gating wrong");
   chk_grant_resume: assert property (@(posedge mclk) disable iff (!nrst)
      state == CPLSC_GRANT && stp_s |=> state == CPLSC_RUN && clk_en == '1)
      else $error("clock stop release failed");
   chk_tri_quiet: assert property (@(posedge mclk) disable iff (!nrst)
      outputs_tristate |-> !ack_oe)
      else $error("ack driven while tristated");
   cov_grant: cover property (@(posedge mclk) disable iff (!nrst) state == CPLSC_GRANT);
   cov_sleep: cover property (@(posedge mclk) disable iff (!nrst) state == CPLSC_SLEEP);
   cov_deep: cover property (@(posedge mclk) disable iff (!nrst) state == CPLSC_DEEP);
   cov_handler: cover property (@(posedge mclk) disable iff (!nrst) handler_mode);
endmodule

/* File: testbench/cplsc_chipset.sv */
// cplsc_chipset: system logic model driving the request pins and the bus clock
// assumes the bench sets wanted pin levels; stop, sleep and deep pins move on the falling mclk edge
`timescale 1ns/100ps
module cplsc_chipset
(
   input wire logic mclk, // system clock
   input wire logic bclk_run, // bus clock toggles while high
   input wire logic [3:0] want_n, // wanted levels: stop, sleep, deep, mgmt
   output logic bclk_in, // bus clock
   output logic clock_stop_request_n, // clock stop request
   output logic sleep_request_n, // sleep request
   output logic deep_sleep_request_n, // deep sleep request
   output logic mgmt_interrupt_n // management interrupt
);
   // idle levels at time zero
   initial
   begin
      bclk_in = 1'b0;
      {clock_stop_request_n, sleep_request_n, deep_sleep_request_n, mgmt_interrupt_n} = 4'hF;
   end
   // bus clock and the stop, sleep and deep request pins change on the falling edge
   always @(negedge mclk)
   begin
      if (bclk_run)
      begin
         bclk_in <= ~bclk_in;
      end
      {clock_stop_request_n, sleep_request_n, deep_sleep_request_n} <= want_n[3:1];
   end
   // management interrupt lands off the mclk grid
   always @(want_n[0])
   begin
      mgmt_interrupt_n <= #7 want_n[0];
   end
endmodule

/* File: testbench/cpu_low_power_state_control_bench.sv */
// cpu_low_power_state_control_bench: walks the power states and judges the outputs
// assumes the chipset model drives the request pins and bus clock
`timescale 1ns/100ps
module cpu_low_power_state_control_bench;
   import cplsc_pkg::*;
   logic mclk = 1'b0;
   logic nrst = 1'b0;
   logic bclk_run = 1'b1;
   logic [3:0] want_n = 4'hF;
   logic handler_exit = 1'b0;
   logic snoop_req = 1'b0;
   logic intr_req = 1'b0;
   logic bclk_in, sleep_request_n, deep_sleep_request_n, clock_stop_request_n, mgmt_interrupt_n;
   logic [CPLSC_GATE_W-1:0] clk_en;
   logic [1:0] ack_code;
   logic ack_valid, ack_oe, save_state, handler_mode, snoop_ack, intr_ack, outputs_tristate;
   logic [2:0] state_out;
   int mismatches = 0;
   int total_checks = 0;
   // 20 MHz clock
   always #25 mclk = ~mclk;
   cplsc_chipset partner (.mclk(mclk), .bclk_run(bclk_run), .want_n(want_n), .bclk_in(bclk_in),
      .clock_stop_request_n(clock_stop_request_n), .sleep_request_n(sleep_request_n),
      .deep_sleep_request_n(deep_sleep_request_n), .mgmt_interrupt_n(mgmt_interrupt_n));
   cplsc_ctrl DUT (.mclk(mclk), .nrst(nrst), .bclk_in(bclk_in), .sleep_request_n(sleep_request_n),
      .deep_sleep_request_n(deep_sleep_request_n), .clock_stop_request_n(clock_stop_request_n),
      .mgmt_interrupt_n(mgmt_interrupt_n), .handler_exit(handler_exit), .snoop_req(snoop_req),
      .intr_req(intr_req), .clk_en(clk_en), .ack_code(ack_code), .ack_valid(ack_valid),
      .ack_oe(ack_oe), .save_state(save_state), .handler_mode(handler_mode), .snoop_ack(snoop_ack),
      .intr_ack(intr_ack), .outputs_tristate(outputs_tristate), .state_out(state_out));
   // counts and verdict
   task automatic end_sim();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // compare one value
   task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
      total_checks++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("unexpected at %0t: %s", $time, what);
      end
   endtask
   // bounded wait for a state, sampled on falling edges
   task automatic wait_state(input logic [2:0] exp);
      int n;
      n = 0;
      @(negedge mclk);
      while (state_out !== exp && n < 30)
      begin
         @(negedge mclk);
         n++;
      end
      check({5'h00, state_out}, {5'h00, exp}, "state");
      if (state_out !== exp)
         end_sim();
   endtask
   task automatic t_reset(input logic mgmt, input logic tri_exp);
      @(negedge mclk);
      nrst = 1'b0;
      want_n = {3'h7, mgmt};
      repeat (4) @(negedge mclk);
      check({5'h00, clk_en}, 8'h07, "reset gates");
      nrst = 1'b1;
      repeat (3) @(negedge mclk);
      check({7'h00, outputs_tristate}, {7'h00, tri_exp}, "tristate");
      check({7'h00, ack_oe}, 8'h00, "tristate ack");
      $display("reset test done");
   endtask
   task automatic t_grant();
      want_n[3] = 1'b0;
      wait_state(3'h1);
      check({4'h0, ack_oe, ack_valid, ack_code}, 8'h0D, "grant ack");
      check({5'h00, clk_en}, 8'h06, "grant gates");
      snoop_req = 1'b1;
      intr_req = 1'b1;
      repeat (2) @(negedge mclk);
      check({6'h00, snoop_ack, intr_ack}, 8'h03, "grant service");
      snoop_req = 1'b0;
      intr_req = 1'b0;
      $display("grant test done");
   endtask
   task automatic t_sleep();
      want_n[2] = 1'b0;
      wait_state(3'h2);
      check({5'h00, clk_en}, 8'h00, "sleep gates");
      snoop_req = 1'b1;
      intr_req = 1'b1;
      want_n = 4'hA;
      repeat (8) @(negedge mclk);
      check({5'h00, state_out}, 8'h02, "sleep held");
      check({6'h00, snoop_ack, intr_ack}, 8'h00, "sleep ignores");
      snoop_req = 1'b0;
      intr_req = 1'b0;
      want_n = 4'h3;
      repeat (4) @(negedge mclk);
      $display("sleep test done");
   endtask
   task automatic t_deep();
      want_n[1] = 1'b0;
      wait_state(3'h3);
      want_n[1] = 1'b1;
      wait_state(3'h2);
      bclk_run = 1'b0;
      wait_state(3'h3);
      bclk_run = 1'b1;
      wait_state(3'h2);
      $display("deep test done");
   endtask
   task automatic t_wake();
      want_n[2] = 1'b1;
      wait_state(3'h1);
      check({5'h00, clk_en}, 8'h06, "wake gates");
      want_n[3] = 1'b1;
      wait_state(3'h0);
      check({5'h00, clk_en}, 8'h07, "run gates");
      $display("wake test done");
   endtask
   task automatic t_mgmt();
      want_n[0] = 1'b0;
      wait_state(3'h4);
      check({2'h0, ack_oe, handler_mode, save_state, ack_valid, ack_code}, 8'h3E, "handler entry");
      want_n[0] = 1'b1;
      // let the released pin clear the sync chain before leaving the handler
      repeat (4) @(negedge mclk);
      handler_exit = 1'b1;
      @(negedge mclk);
      handler_exit = 1'b0;
      wait_state(3'h0);
      $display("mgmt test done");
   endtask
   // main sequence
   initial
   begin
      t_reset(1'b0, 1'b1);
      t_reset(1'b1, 1'b0);
      t_grant();
      t_sleep();
      t_deep();
      t_wake();
      t_mgmt();
      end_sim();
   end
endmodule
